// *** hw/clock_config_decode.sv ***
// Decodes the system settings word into clock and mode controls.
// Combinational; clk and sys_rst serve only the checks.
`timescale 1ns/100ps
`default_nettype none
module clock_config_decode (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] sys_word,
    output sys_clock_pkg::clock_cfg_t cfg
);
    import sys_clock_pkg::*;

    function automatic logic [16:0] rate_hz(input logic [4:0] code);
        case (code[4:1])
            4'h0: rate_hz = 17'h03e80;
            4'h1: rate_hz = 17'h07d00;
            4'h2: rate_hz = 17'h0fa00;
            4'h3: rate_hz = 17'h05622;
            4'h4: rate_hz = 17'h0ac44;
            4'h5: rate_hz = 17'h15888;
            4'h6: rate_hz = 17'h05dc0;
            4'h7: rate_hz = 17'h0bb80;
            4'h8: rate_hz = 17'h17700;
            default: rate_hz = 17'h00000;
        endcase
    endfunction

    logic [4:0] div;
    logic [1:0] sel;
    assign div = sys_word[DIV_HI:DIV_LO];
    assign sel = sys_word[CLKSEL_HI:CLKSEL_LO];

    always_comb begin
        cfg.osc_pll_power_on = sys_word[POS_PON];
        cfg.crystal_divider_select = div;
        cfg.app_mode = sys_word[MODE_HI:MODE_LO];
        cfg.word_select_detector_on = sys_word[POS_WSD_EN];
        cfg.word_select_detector_limit = sys_word[POS_WSD_LIM] ? WSD_LIMIT_HIGH : WSD_LIMIT_LOW;
        cfg.clock_output_source = sel;
        cfg.clock_out_kind = sel[1] ? CLKOUT_XTAL : (sel[0] ? CLKOUT_PLL_384 : CLKOUT_PLL_256);
        cfg.sample_rate_hz = rate_hz(div);
        cfg.rate_valid = (rate_hz(div) != 17'h00000);
        cfg.sys_ratio_384 = div[0];
        cfg.xtal_bit_clock_ratio = div[0] ? BCLK_RATIO_384 : BCLK_RATIO_256;
        cfg.pll_bit_clock_ratio = sel[0] ? BCLK_RATIO_384 : BCLK_RATIO_256;
    end

    chk_pon_follow: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.osc_pll_power_on == sys_word[POS_PON]) else $error("power bit not followed");
    chk_xtal_bclk_ratio: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.sys_ratio_384 |-> cfg.xtal_bit_clock_ratio == 7'h30) else $error("crystal bit clock ratio wrong");
    chk_rate_family: assert property (@(posedge clk) disable iff (sys_rst)
        (div == 5'h08) |-> (cfg.sample_rate_hz == 17'h0ac44 && !cfg.sys_ratio_384)) else $error("rate decode wrong");
    chk_wsd_limit: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.word_select_detector_limit == (sys_word[POS_WSD_LIM] ? 12'd2047 : 12'd4095)) else $error("detector limit wrong");
    chk_pll_bclk: assert property (@(posedge clk) disable iff (sys_rst)
        (sel == 2'h0 || sel == 2'h2) |-> cfg.pll_bit_clock_ratio == 7'h40) else $error("pll bit clock ratio wrong");
    chk_clkout_kind: assert property (@(posedge clk) disable iff (sys_rst)
        sel[1] |-> cfg.clock_out_kind == CLKOUT_XTAL) else $error("clock output source wrong");
endmodule
`default_nettype wire

// *** hw/sys_clock_pkg.sv ***
// Package for the system clock and mode settings register.
// Assumes a single 200 MHz clock domain and the two-wire control bus.
package sys_clock_pkg;
    localparam logic [6:0] DEVICE_ADDR = 7'h1a;
    localparam logic [7:0] REG_SYS_ADDR = 8'h00;
    localparam logic [15:0] SYS_RESET = 16'h282a;
    localparam logic [15:0] RESERVED_MASK = 16'h4000;
    localparam int POS_FACTORY = 15;
    localparam int POS_PON = 13;
    localparam int DIV_HI = 12;
    localparam int DIV_LO = 8;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 4;
    localparam int POS_WSD_EN = 3;
    localparam int POS_WSD_LIM = 2;
    localparam int CLKSEL_HI = 1;
    localparam int CLKSEL_LO = 0;
    localparam logic [11:0] WSD_LIMIT_LOW = 12'hfff;
    localparam logic [11:0] WSD_LIMIT_HIGH = 12'h7ff;
    localparam logic [6:0] BCLK_RATIO_256 = 7'h40;
    localparam logic [6:0] BCLK_RATIO_384 = 7'h30;
    localparam logic [1:0] CLKOUT_PLL_256 = 2'h0;
    localparam logic [1:0] CLKOUT_PLL_384 = 2'h1;
    localparam logic [1:0] CLKOUT_XTAL = 2'h2;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef struct packed {
        logic osc_pll_power_on;
        logic [4:0] crystal_divider_select;
        logic [3:0] app_mode;
        logic word_select_detector_on;
        logic [11:0] word_select_detector_limit;
        logic [1:0] clock_output_source;
        logic [1:0] clock_out_kind;
        logic rate_valid;
        logic [16:0] sample_rate_hz;
        logic sys_ratio_384;
        logic [6:0] xtal_bit_clock_ratio;
        logic [6:0] pll_bit_clock_ratio;
    } clock_cfg_t;
endpackage

// *** hw/system_clock_mode_config.sv ***
// System settings register behind a two-wire control bus slave.
// Assumes scl and sda arrive asynchronously; sda is open-drain outside.
// Function
// - Power bit 13 stops or runs oscillator, PLL
// - Divider field picks rate and 256/384 ratio
// - Codes map rate families; odd code means 384
// - Mode field selects mode 0 to 15
// - Bits 7 to 4 hold application mode
// - Bit 3 enables word-select detector
// - Bit 2 picks 4095 or 2047 limit
// - Clock select picks PLL 256, 384, crystal
// - PLL bit clock 64 for 00/10 else 48
// - 16-bit words, MS byte first, auto-increment
`timescale 1ns/100ps
`default_nettype none
module system_clock_mode_config (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output sys_clock_pkg::clock_cfg_t cfg
);
    import sys_clock_pkg::*;

    typedef enum logic [2:0] {st_idle, st_dev, st_reg, st_wr, st_rd} bus_state_t;

    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    bus_state_t state;
    logic [3:0] bit_cnt;
    logic ack_phase, msb_phase, rw_read;
    logic [7:0] shift, tx, wr_ms, reg_addr;
    logic [15:0] sys_reg, wr_word, rd_val;
    logic commit;

    // Two flops on each pin before any logic looks at it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

    // Unmapped addresses read as zero and swallow writes
    function automatic logic [15:0] rd_word(input logic [7:0] addr, input logic [15:0] r);
        rd_word = (addr == REG_SYS_ADDR) ? r : 16'h0000;
    endfunction
    assign rd_val = rd_word(reg_addr, sys_reg);

    // Bus protocol: addressing, byte pairing and acknowledge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= st_idle;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            msb_phase <= 1'b1;
            rw_read <= 1'b0;
            shift <= 8'h00;
            tx <= 8'h00;
            wr_ms <= 8'h00;
            reg_addr <= 8'h00;
            wr_word <= 16'h0000;
            commit <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            commit <= 1'b0;
            if (start_det) begin
                state <= st_dev;
                bit_cnt <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state <= st_idle;
                sda_oe <= 1'b0;
            end else if (state != st_idle && scl_rise) begin
                if (bit_cnt != BIT_ACK) begin
                    shift <= {shift[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (state == st_rd && ack_phase && sda_s) begin
                    state <= st_idle;
                end
            end else if (state != st_idle && scl_fall) begin
                if (bit_cnt == BIT_ACK && !ack_phase) begin
                    ack_phase <= 1'b1;
                    case (state)
                        st_dev: begin
                            rw_read <= shift[0];
                            if (shift[7:1] == DEVICE_ADDR) begin
                                sda_oe <= 1'b1;
                            end else begin
                                state <= st_idle;
                            end
                        end
                        st_reg: begin
                            reg_addr <= shift;
                            sda_oe <= 1'b1;
                        end
                        st_wr: begin
                            sda_oe <= 1'b1;
                            msb_phase <= ~msb_phase;
                            if (msb_phase) begin
                                wr_ms <= shift;
                            end else begin
                                wr_word <= {wr_ms, shift};
                                commit <= (reg_addr == REG_SYS_ADDR);
                                reg_addr <= reg_addr + 8'h01;
                            end
                        end
                        st_rd: begin
                            sda_oe <= 1'b0;
                            msb_phase <= ~msb_phase;
                            if (!msb_phase) begin
                                reg_addr <= reg_addr + 8'h01;
                            end
                        end
                        default: sda_oe <= 1'b0;
                    endcase
                end else if (ack_phase) begin
                    ack_phase <= 1'b0;
                    bit_cnt <= 4'h0;
                    sda_oe <= 1'b0;
                    case (state)
                        st_dev: begin
                            msb_phase <= 1'b1;
                            if (rw_read) begin
                                state <= st_rd;
                                tx <= {rd_val[14:8], 1'b0};
                                sda_oe <= ~rd_val[15];
                            end else begin
                                state <= st_reg;
                            end
                        end
                        st_reg: state <= st_wr;
                        st_rd: begin
                            // Byte order: MS byte of the word first
                            if (msb_phase) begin
                                tx <= {rd_val[14:8], 1'b0};
                                sda_oe <= ~rd_val[15];
                            end else begin
                                tx <= {rd_val[6:0], 1'b0};
                                sda_oe <= ~rd_val[7];
                            end
                        end
                        default: state <= state;
                    endcase
                end else if (state == st_rd) begin
                    sda_oe <= (bit_cnt == BIT_ACK) ? 1'b0 : ~tx[7];
                    tx <= {tx[6:0], 1'b0};
                end
            end
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;

    // Settings register; bit 15 stored as the controller wrote it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sys_reg <= SYS_RESET;
        end else if (commit) begin
            sys_reg <= wr_word & ~RESERVED_MASK;
        end
    end

    clock_config_decode clock_config_decode_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .sys_word(sys_reg),
        .cfg(cfg)
    );

    chk_reset_defaults: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> sys_reg == 16'h282a) else $error("reset value wrong");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
        sys_reg[14] == 1'b0) else $error("reserved bit set");
    chk_write_commit: assert property (@(posedge clk) disable iff (sys_rst)
        commit |=> sys_reg == ($past(wr_word) & 16'hbfff)) else $error("write not stored");
    chk_addr_incr: assert property (@(posedge clk) disable iff (sys_rst)
        (state == st_wr && scl_fall && bit_cnt == BIT_ACK && !ack_phase && !msb_phase && !start_det && !stop_det)
        |=> reg_addr == $past(reg_addr) + 8'h01) else $error("address not incremented");
    chk_ack_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (state == st_dev && scl_fall && bit_cnt == BIT_ACK && !ack_phase && !start_det && !stop_det
        && shift[7:1] == 7'h1a) |=> sda_oe) else $error("own address not acknowledged");
    chk_foreign_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (state == st_dev && scl_fall && bit_cnt == BIT_ACK && !ack_phase && !start_det && !stop_det
        && shift[7:1] != 7'h1a) |=> (state == st_idle && !sda_oe)) else $error("foreign address answered");
    chk_idle_release: assert property (@(posedge clk) disable iff (sys_rst)
        state == st_idle |-> !sda_oe) else $error("data line held while idle");

    cov_write_word: cover property (@(posedge clk) disable iff (sys_rst) commit);
    cov_read_start: cover property (@(posedge clk) disable iff (sys_rst) state == st_dev ##1 state == st_rd);
    cov_power_off: cover property (@(posedge clk) disable iff (sys_rst) !sys_reg[POS_PON]);
    cov_read_nack: cover property (@(posedge clk) disable iff (sys_rst) state == st_rd ##1 state == st_idle);
endmodule
`default_nettype wire

// *** sim/ctrl_bus_master.sv ***
// Two-wire control bus controller model, driven by bench task calls.
// Assumes a pull-up outside: the wire is high unless somebody pulls it.
`timescale 1ns/100ps
`default_nettype none
module ctrl_bus_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic pull_low
);
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // Six clocks a phase; the slave synchroniser and edge detect are three flops deep
    task automatic phase();
        repeat (6) @(posedge clk);
        #1;
    endtask
    // Works as first start and repeated start
    task automatic start();
        phase();
        pull_low = 1'b0;
        phase();
        scl = 1'b1;
        phase();
        pull_low = 1'b1;
        phase();
        scl = 1'b0;
    endtask
    task automatic stop();
        phase();
        pull_low = 1'b1;
        phase();
        scl = 1'b1;
        phase();
        pull_low = 1'b0;
        phase();
    endtask
    // Data moves only while scl is low, so no false start or stop
    task automatic send_bit(input logic b, output logic got);
        phase();
        pull_low = ~b;
        phase();
        scl = 1'b1;
        phase();
        got = sda;
        scl = 1'b0;
    endtask
    // MS bit first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic ack_out, output logic ack_in);
        for (int i = 7; i >= 0; i--) begin
            send_bit(tx[i], rx[i]);
        end
        send_bit(ack_out, ack_in);
    endtask
endmodule
`default_nettype wire

// *** sim/system_clock_mode_config_tb.sv ***
// Self-checking bench for the system settings register block.
// Assumes the controller model above; sda is wired-and with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module system_clock_mode_config_tb;
    import sys_clock_pkg::*;
    logic clk, sys_rst, scl, pull_low, sda_oe, sda_o;
    wire sda;
    clock_cfg_t cfg;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [16:0] rates[10] = '{17'h03e80, 17'h07d00, 17'h0fa00, 17'h05622, 17'h0ac44, 17'h15888,
        17'h05dc0, 17'h0bb80, 17'h17700, 17'h00000};
    assign sda = ~(pull_low | sda_oe);
    ctrl_bus_master ctrl_bus_master_i (.clk(clk), .sda(sda), .scl(scl), .pull_low(pull_low));
    system_clock_mode_config system_clock_mode_config_i (.clk(clk), .sys_rst(sys_rst), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Full run is about 31000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] ra, input logic [15:0] d0, input logic [15:0] d1,
        input int n);
        logic [7:0] rx;
        logic a;
        ctrl_bus_master_i.start();
        ctrl_bus_master_i.xfer(dev, rx, 1'b1, a);
        check(a, dev != 8'h34, "device ack");
        if (!a) begin
            ctrl_bus_master_i.xfer(ra, rx, 1'b1, a);
            for (int i = 0; i < 2 * n; i++) begin
                ctrl_bus_master_i.xfer(i[1] ? d1[15-8*i[0] -: 8] : d0[15-8*i[0] -: 8], rx, 1'b1, a);
                check(a, 1'b0, "data ack");
            end
        end
        ctrl_bus_master_i.stop();
    endtask
    task automatic rd(input logic [7:0] ra, output logic [15:0] w0, output logic [15:0] w1);
        logic a;
        ctrl_bus_master_i.start();
        ctrl_bus_master_i.xfer(8'h34, w0[7:0], 1'b1, a);
        ctrl_bus_master_i.xfer(ra, w0[7:0], 1'b1, a);
        ctrl_bus_master_i.start();
        ctrl_bus_master_i.xfer(8'h35, w0[7:0], 1'b1, a);
        check(a, 1'b0, "read ack");
        ctrl_bus_master_i.xfer(8'hff, w0[15:8], 1'b0, a);
        ctrl_bus_master_i.xfer(8'hff, w0[7:0], 1'b0, a);
        ctrl_bus_master_i.xfer(8'hff, w1[15:8], 1'b0, a);
        ctrl_bus_master_i.xfer(8'hff, w1[7:0], 1'b1, a);
        ctrl_bus_master_i.stop();
    endtask
    task automatic t_reset();
        logic [15:0] w0, w1;
        check({cfg.osc_pll_power_on, cfg.crystal_divider_select, cfg.app_mode}, 10'h282, "reset cfg");
        check({cfg.word_select_detector_on, cfg.word_select_detector_limit, cfg.clock_output_source},
            15'h7ffe, "reset detector");
        check(sda_o, 1'b0, "open drain level");
        rd(8'h00, w0, w1);
        check(w0, 16'h282a, "reset word");
        check(w1, 16'h0000, "unmapped read");
    endtask
    task automatic t_divider();
        for (int c = 0; c < 19; c++) begin
            wr(8'h34, 8'h00, {3'h1, c[4:0], 8'h2a}, 16'h0000, 1);
            check(cfg.crystal_divider_select, c[4:0], "divider");
            check(cfg.sample_rate_hz, rates[c/2], "rate");
            check(cfg.rate_valid, c < 18, "rate valid");
            check(cfg.sys_ratio_384, c[0], "ratio");
            check(cfg.xtal_bit_clock_ratio, c[0] ? 7'h30 : 7'h40, "xtal bclk");
        end
    endtask
    task automatic t_fields();
        logic [15:0] w0, w1, w;
        rd(8'h00, w0, w1);
        for (int k = 0; k < 16; k++) begin
            // Bit 15 written back as read
            w = {w0[15], 1'b1, k[2], 5'h08, k[3:0], k[3], k[0], k[1:0]};
            wr(8'h34, 8'h00, w, 16'h0000, 1);
            check(cfg.osc_pll_power_on, k[2], "power");
            check(cfg.app_mode, k[3:0], "mode");
            check(cfg.word_select_detector_on, k[3], "detector on");
            check(cfg.word_select_detector_limit, k[0] ? 12'h7ff : 12'hfff, "limit");
            check(cfg.clock_out_kind, k[1] ? 2'h2 : k[1:0], "clock out");
            check(cfg.clock_output_source, k[1:0], "clock select");
            check(cfg.pll_bit_clock_ratio, k[0] ? 7'h30 : 7'h40, "pll bclk");
        end
        rd(8'h00, w0, w1);
        check(w0, w & 16'hbfff, "bit 14 zero");
    endtask
    task automatic t_autoinc();
        logic [15:0] w0, w1;
        wr(8'h34, 8'h00, 16'h2125, 16'h0f0f, 2);
        wr(8'h34, 8'h01, 16'h3333, 16'h0000, 1);
        wr(8'h36, 8'h00, 16'h0000, 16'h0000, 1);
        rd(8'h00, w0, w1);
        check(w0, 16'h2125, "first word kept");
        check(w1, 16'h0000, "second word");
    endtask
    // Reset in mid-run must bring defaults back over written values
    task automatic t_rerst();
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(cfg.crystal_divider_select, 5'h08, "rerun divider");
        check(cfg.word_select_detector_limit, 12'hfff, "rerun limit");
    endtask
    initial begin
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_divider();
        t_fields();
        t_autoinc();
        t_rerst();
        final_report();
    end
endmodule
`default_nettype wire
